// file: rtl/mocfg_pkg.sv
package mocfg_pkg;
  // Byte addresses of the registers on the bus.
  localparam logic [15:0] ADDR_WDOG_SERVICE = 16'h001D;
  localparam logic [15:0] ADDR_WDOG_CTRL = 16'h001E;
  localparam logic [15:0] ADDR_SW_OPTION = 16'h3FDF;
  localparam logic [15:0] ADDR_LEGACY_CLEAR = 16'h3FF0;
  localparam logic [15:0] ADDR_LEGACY_OPTION = 16'h3FF1;
  localparam logic [15:0] ADDR_PORTB_OPTION = 16'h3FF2;
  localparam logic [15:0] ADDR_PORTD_DIR = 16'h0007;
  localparam logic [15:0] ADDR_SERIAL_CTRL = 16'h000A;
  localparam logic [15:0] ADDR_STATUS = 16'h3FF3;
  // Field positions in the legacy mode option register.
  localparam int LMO_MODE_BIT = 0;
  localparam int LMO_IRQ_BIT = 1;
  localparam int LMO_STOP_BIT = 2;
  localparam int LMO_WDOG_BIT = 3;
  localparam int LMO_SEC_BIT = 4;
  // Field positions in the software option register.
  localparam int SWO_IRQ_BIT = 1;
  localparam int SWO_HIGH_BIT = 6;
  localparam int SWO_LOW_BIT = 7;
  // Open-drain enable in the serial peripheral control register.
  localparam int SPC_OPEN_DRAIN_BIT = 5;
  // Status register fields.
  localparam int STA_LEGACY_BIT = 0;
  localparam int STA_ONCE_BIT = 1;
  // Reset values.
  localparam logic [7:0] SW_OPTION_RESET = 8'h02;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [6:0] DIR_ZERO = 7'h00;
  // Port D bits used by the serial outputs: data in, data out, clock.
  localparam int PD_MISO = 2;
  localparam int PD_MOSI = 3;
  localparam int PD_SCK = 4;
  // Bus answer states, one-hot.
  typedef enum logic [1:0] {
    MOCFG_IDLE = 2'b01,
    MOCFG_DONE = 2'b10
  } mocfg_bus_e;
endpackage

// file: rtl/mocfg_top.sv
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
module mocfg_top
  import mocfg_pkg::*;
(
  input wire logic sys_clk_in, // 10 MHz bus clock.
  input wire logic reset_in, // Synchronous reset, active high, any cause.
  input wire logic por_in, // Power-on reset pulse, async to logic.
  input wire logic [7:0] nv_legacy_opt_in, // Programmed legacy option byte.
  input wire logic [7:0] nv_portb_opt_in, // Programmed port B option byte.
  input wire logic wdog_timeout_in, // Full-mode watchdog timeout.
  input wire logic clkmon_timeout_in, // Clock monitor timeout.
  input wire logic [2:0] spi_drive_in, // Serial outputs want to drive.
  input wire logic [15:0] avs_address, // Avalon byte address.
  input wire logic avs_read, // Avalon read.
  input wire logic avs_write, // Avalon write.
  input wire logic [7:0] avs_writedata, // Avalon write data.
  output logic [7:0] avs_readdata, // Avalon read data.
  output logic avs_waitrequest, // Avalon wait.
  output logic legacy_mode_out, // 1 in legacy mode.
  output logic [7:0] portb_pullup_irq_en_out, // Port B pullup and interrupt enables.
  output logic irq_level_sense_out, // Edge-and-level for irq and port B.
  output logic stop_clkmon_en_out, // Clock monitor armed on stop.
  output logic legacy_watchdog_en_out, // Legacy watchdog on.
  output logic legacy_watchdog_clear_out, // One-cycle legacy watchdog clear.
  output logic security_out, // Block EPROM verify and modify.
  output logic full_wdog_regs_en_out, // Full-mode watchdog regs enabled.
  output logic full_wdog_service_out, // One-cycle service write pulse.
  output logic [7:0] full_wdog_ctrl_out, // Full-mode watchdog control.
  output logic upper_map_en_out, // Range up to overlay top enabled.
  output logic overlay_low_ram_out, // RAM in the 48-byte window.
  output logic overlay_high_ram_out, // RAM in the 128-byte window.
  output logic [6:0] portd_dir_out, // Effective port D directions.
  output logic [2:0] spi_oe_out, // Serial output enables.
  output logic portd_open_drain_out, // Port D open-drain.
  output logic reset_pin_o_out, // Reset pin drive level.
  output logic reset_pin_oe_out // Reset pin drive enable.
);

  typedef struct packed {
    logic por_m;
    logic por_s;
    logic legacy;
    logic [7:0] lopt;
    logic [7:0] pbopt;
    logic [7:0] swopt;
    logic once;
    logic [7:0] wctrl;
    logic [6:0] ddr;
    logic [7:0] serial_periph_ctrl_reg;
    logic [7:0] rdata;
    mocfg_bus_e bus;
    logic wdclr;
    logic wsvc;
    logic rst_drv;
    logic [2:0] spi_oe;
    logic busy;
    logic stop_en;
    logic lwd_en;
    logic full;
    logic ovl_lo;
    logic ovl_hi;
    logic [6:0] pd_dir;
    logic od;
    logic sense;
  } mocfg_state_s;

  mocfg_state_s q, d;
  logic acc;
  logic wr_now;
  logic rd_hit;
  logic [7:0] rd_val;

  // A request is taken while idle; a write lands only in the answer cycle, at the
  // edge where the master sees waitrequest low, so a held request never lands twice.
  assign acc = (avs_read | avs_write) && q.bus == MOCFG_IDLE;
  assign wr_now = avs_write && q.bus == MOCFG_DONE;

  // Read decode; disabled registers read as zero, like unmapped space.
  always_comb begin
    rd_val = BYTE_ZERO;
    case (avs_address)
      ADDR_SW_OPTION: begin
        if (!q.legacy) begin
          rd_val = q.swopt;
        end
      end
      ADDR_WDOG_CTRL: begin
        if (!q.legacy) begin
          rd_val = q.wctrl;
        end
      end
      ADDR_LEGACY_OPTION: begin
        rd_val = q.lopt;
        if (!q.legacy) begin
          rd_val[LMO_IRQ_BIT] = 1'b0;
          rd_val[LMO_STOP_BIT] = 1'b0;
          rd_val[LMO_WDOG_BIT] = 1'b0;
        end
      end
      ADDR_PORTB_OPTION: rd_val = q.pbopt;
      ADDR_PORTD_DIR: begin
        if (!q.legacy) begin
          rd_val = {1'b0, q.ddr};
        end
      end
      ADDR_SERIAL_CTRL: rd_val = q.serial_periph_ctrl_reg;
      ADDR_STATUS: begin
        rd_val[STA_LEGACY_BIT] = q.legacy;
        rd_val[STA_ONCE_BIT] = q.once;
      end
      default: rd_val = BYTE_ZERO;
    endcase
  end
  assign rd_hit = avs_read;

  // Next state: option capture, register writes and derived outputs.
  always_comb begin
    d = q;
    d.por_m = por_in;
    d.por_s = q.por_m;
    d.wdclr = 1'b0;
    d.wsvc = 1'b0;
    d.rdata = q.rdata;
    // One wait cycle, then the answer; acceptance is the DONE cycle.
    case (q.bus)
      MOCFG_IDLE: begin
        if (acc) begin
          d.bus = MOCFG_DONE;
          if (rd_hit) begin
            d.rdata = rd_val;
          end
        end
      end
      MOCFG_DONE: d.bus = MOCFG_IDLE;
      default: d.bus = MOCFG_IDLE;
    endcase
    if (wr_now) begin
      case (avs_address)
        ADDR_SW_OPTION: begin
          if (!q.legacy) begin
            d.swopt[SWO_LOW_BIT] = avs_writedata[SWO_LOW_BIT];
            d.swopt[SWO_HIGH_BIT] = avs_writedata[SWO_HIGH_BIT];
            if (!q.once) begin
              d.swopt[SWO_IRQ_BIT] = avs_writedata[SWO_IRQ_BIT];
              d.once = 1'b1;
            end
          end
        end
        ADDR_WDOG_SERVICE: d.wsvc = !q.legacy;
        ADDR_WDOG_CTRL: begin
          if (!q.legacy) begin
            d.wctrl = avs_writedata;
          end
        end
        ADDR_LEGACY_CLEAR: d.wdclr = q.legacy;
        ADDR_PORTD_DIR: begin
          if (!q.legacy) begin
            d.ddr = avs_writedata[6:0];
          end
        end
        ADDR_SERIAL_CTRL: d.serial_periph_ctrl_reg = avs_writedata;
        default: d.serial_periph_ctrl_reg = q.serial_periph_ctrl_reg;
      endcase
    end
    // Full mode gates serial drivers by port D direction bits.
    d.spi_oe[0] = spi_drive_in[0] & (q.legacy | q.ddr[PD_MISO]);
    d.spi_oe[1] = spi_drive_in[1] & (q.legacy | q.ddr[PD_MOSI]);
    d.spi_oe[2] = spi_drive_in[2] & (q.legacy | q.ddr[PD_SCK]);
    d.rst_drv = !q.legacy & (wdog_timeout_in | clkmon_timeout_in | q.por_s);
    // Options are sampled while reset is held; power-on forces full mode.
    if (reset_in) begin
      d.lopt = nv_legacy_opt_in;
      d.pbopt = nv_portb_opt_in;
      d.legacy = nv_legacy_opt_in[LMO_MODE_BIT] & !q.por_s;
      d.swopt = SW_OPTION_RESET;
      d.once = 1'b0;
      d.wctrl = BYTE_ZERO;
      d.ddr = DIR_ZERO;
      d.serial_periph_ctrl_reg = BYTE_ZERO;
      d.bus = MOCFG_IDLE;
      d.rdata = BYTE_ZERO;
      d.wdclr = 1'b0;
      d.wsvc = 1'b0;
      d.spi_oe = 3'h0;
    end
    // Output copies decode the next state, so they move on the same edge as it.
    d.busy = d.bus != MOCFG_DONE;
    d.stop_en = d.legacy & d.lopt[LMO_STOP_BIT];
    d.lwd_en = d.legacy & d.lopt[LMO_WDOG_BIT];
    d.full = !d.legacy;
    d.ovl_lo = !d.legacy & d.swopt[SWO_LOW_BIT];
    d.ovl_hi = !d.legacy & d.swopt[SWO_HIGH_BIT];
    d.pd_dir = d.legacy ? DIR_ZERO : d.ddr;
    d.od = !d.legacy & d.serial_periph_ctrl_reg[SPC_OPEN_DRAIN_BIT];
    d.sense = d.legacy ? d.lopt[LMO_IRQ_BIT] : d.swopt[SWO_IRQ_BIT];
  end

  // State register; the synchroniser stages run through reset too.
  always_ff @(posedge sys_clk_in) begin
    q <= d;
  end

  // Every output but the tied-off reset pin level leaves a flop, so no decode glitch reaches the pins.
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.busy;
  assign legacy_mode_out = q.legacy;
  assign portb_pullup_irq_en_out = q.pbopt;
  assign stop_clkmon_en_out = q.stop_en;
  assign legacy_watchdog_en_out = q.lwd_en;
  assign security_out = q.lopt[LMO_SEC_BIT];
  assign legacy_watchdog_clear_out = q.wdclr;
  assign full_wdog_regs_en_out = q.full;
  assign full_wdog_service_out = q.wsvc;
  assign full_wdog_ctrl_out = q.wctrl;
  assign upper_map_en_out = q.full;
  assign overlay_low_ram_out = q.ovl_lo;
  assign overlay_high_ram_out = q.ovl_hi;
  assign portd_dir_out = q.pd_dir;
  assign spi_oe_out = q.spi_oe;
  assign portd_open_drain_out = q.od;
  // The reset pin is only ever pulled low, so its level is fixed and the enable moves.
  assign reset_pin_o_out = 1'b0;
  assign reset_pin_oe_out = q.rst_drv;
  // One sense select serves the irq pin and the port B interrupts alike.
  assign irq_level_sense_out = q.sense;

  property p_once;
    @(posedge sys_clk_in) disable iff (reset_in)
      q.once |=> $stable(q.swopt[SWO_IRQ_BIT]);
  endproperty
  a_once: assert property (p_once) else $error("sense bit changed after write");

  property p_full_forced;
    @(posedge sys_clk_in) disable iff (reset_in)
      !legacy_mode_out |-> !stop_clkmon_en_out && !legacy_watchdog_en_out;
  endproperty
  a_full_forced: assert property (p_full_forced) else $error("legacy bits active");

  property p_legacy_map;
    @(posedge sys_clk_in) disable iff (reset_in)
      legacy_mode_out |-> !upper_map_en_out && portd_dir_out == DIR_ZERO;
  endproperty
  a_legacy_map: assert property (p_legacy_map) else $error("legacy map wrong");

  sequence s_clr_write;
    avs_write && avs_address == ADDR_LEGACY_CLEAR && !avs_waitrequest && legacy_mode_out;
  endsequence
  property p_clr;
    @(posedge sys_clk_in) disable iff (reset_in)
      s_clr_write |=> legacy_watchdog_clear_out;
  endproperty
  a_clr: assert property (p_clr) else $error("no legacy clear pulse");

  property p_wait;
    @(posedge sys_clk_in) disable iff (reset_in)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");

  property p_rstpin;
    @(posedge sys_clk_in) disable iff (reset_in)
      legacy_mode_out |-> !reset_pin_oe_out;
  endproperty
  a_rstpin: assert property (p_rstpin) else $error("reset pin driven in legacy");

  property p_od;
    @(posedge sys_clk_in) disable iff (reset_in)
      portd_open_drain_out |-> !legacy_mode_out && serial_periph_ctrl_reg_od_bit();
  endproperty
  function automatic logic serial_periph_ctrl_reg_od_bit();
    return q.serial_periph_ctrl_reg[SPC_OPEN_DRAIN_BIT];
  endfunction
  a_od: assert property (p_od) else $error("open drain wrong");

  property p_sense;
    @(posedge sys_clk_in) disable iff (reset_in)
      !legacy_mode_out |-> irq_level_sense_out == q.swopt[SWO_IRQ_BIT];
  endproperty
  a_sense: assert property (p_sense) else $error("sense source wrong");

  // Power-on forces full map mode whatever the mode bit holds.
  property p_por_full;
    @(posedge sys_clk_in)
      reset_in && q.por_s |=> !legacy_mode_out;
  endproperty
  a_por_full: assert property (p_por_full) else $error("power-on left legacy mode");

  // Without power-on, a reset takes the mode straight from the option bit.
  property p_mode_sel;
    @(posedge sys_clk_in)
      reset_in && !q.por_s |=> legacy_mode_out == $past(nv_legacy_opt_in[LMO_MODE_BIT]);
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode ignores option bit");

  // After reset the full-mode sense is edge-and-level and its one write is unused.
  property p_sense_reset;
    @(posedge sys_clk_in) disable iff (reset_in)
      $fell(reset_in) && !legacy_mode_out |-> irq_level_sense_out && !q.once;
  endproperty
  a_sense_reset: assert property (p_sense_reset) else $error("sense reset value wrong");

  // An accepted full-mode write to the software option register.
  sequence s_opt_write;
    avs_write && !avs_waitrequest && avs_address == ADDR_SW_OPTION && !legacy_mode_out;
  endsequence

  // The first write after reset sets the sense bit and uses up the write.
  property p_sense_first;
    @(posedge sys_clk_in) disable iff (reset_in)
      s_opt_write ##0 !q.once |=>
        irq_level_sense_out == $past(avs_writedata[SWO_IRQ_BIT]) && q.once;
  endproperty
  a_sense_first: assert property (p_sense_first) else $error("first sense write lost");

  // Later writes leave the sense bit alone.
  property p_sense_late;
    @(posedge sys_clk_in) disable iff (reset_in)
      s_opt_write ##0 q.once |=> $stable(irq_level_sense_out);
  endproperty
  a_sense_late: assert property (p_sense_late) else $error("late sense write landed");

  // Overlay bits may be rewritten at any time in full mode.
  property p_overlay;
    @(posedge sys_clk_in) disable iff (reset_in)
      s_opt_write |=> overlay_low_ram_out == $past(avs_writedata[SWO_LOW_BIT]) &&
        overlay_high_ram_out == $past(avs_writedata[SWO_HIGH_BIT]);
  endproperty
  a_overlay: assert property (p_overlay) else $error("overlay write lost");

  // An accepted full-mode write to the port D direction register.
  sequence s_dir_write;
    avs_write && !avs_waitrequest && avs_address == ADDR_PORTD_DIR && !legacy_mode_out;
  endsequence
  property p_dir;
    @(posedge sys_clk_in) disable iff (reset_in)
      s_dir_write |=> portd_dir_out == $past(avs_writedata[6:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction write lost");

  // An accepted full-mode write to the watchdog service register.
  sequence s_svc_write;
    avs_write && !avs_waitrequest && avs_address == ADDR_WDOG_SERVICE && !legacy_mode_out;
  endsequence
  property p_svc;
    @(posedge sys_clk_in) disable iff (reset_in)
      s_svc_write |=> full_wdog_service_out;
  endproperty
  a_svc: assert property (p_svc) else $error("no service pulse");

  // The legacy clear register is dead in full mode.
  property p_no_clear_full;
    @(posedge sys_clk_in) disable iff (reset_in)
      !legacy_mode_out |-> !legacy_watchdog_clear_out;
  endproperty
  a_no_clear_full: assert property (p_no_clear_full) else $error("clear in full mode");

  // The full-mode service register is dead in legacy mode.
  property p_no_svc_legacy;
    @(posedge sys_clk_in) disable iff (reset_in)
      legacy_mode_out |-> !full_wdog_service_out;
  endproperty
  a_no_svc_legacy: assert property (p_no_svc_legacy) else $error("service in legacy");

  // Full mode opens the whole map and the watchdog registers.
  property p_full_en;
    @(posedge sys_clk_in) disable iff (reset_in)
      !legacy_mode_out |-> upper_map_en_out && full_wdog_regs_en_out;
  endproperty
  a_full_en: assert property (p_full_en) else $error("full map not enabled");

  // Programmed options only change while reset samples them.
  property p_opts_hold;
    @(posedge sys_clk_in) disable iff (reset_in)
      $stable({portb_pullup_irq_en_out, security_out});
  endproperty
  a_opts_hold: assert property (p_opts_hold) else $error("options moved");

  // In full mode a serial driver is only enabled where its direction bit is set.
  property p_spi_gate;
    @(posedge sys_clk_in) disable iff (reset_in)
      !legacy_mode_out |=> (spi_oe_out & ~{$past(portd_dir_out[PD_SCK]),
        $past(portd_dir_out[PD_MOSI]), $past(portd_dir_out[PD_MISO])}) == '0;
  endproperty
  a_spi_gate: assert property (p_spi_gate) else $error("serial drive ungated");

  // A timeout in full mode pulls the reset pin on the next edge.
  property p_rst_drive;
    @(posedge sys_clk_in) disable iff (reset_in)
      !legacy_mode_out && (wdog_timeout_in || clkmon_timeout_in) |=> reset_pin_oe_out;
  endproperty
  a_rst_drive: assert property (p_rst_drive) else $error("reset pin not driven");

endmodule

// file: tb/mocfg_top_tb.sv
`timescale 1ns/1ps
module mocfg_top_tb
  import mocfg_pkg::*;
;
  logic sys_clk_in = 1'h0;
  logic reset_in, por_in, wdog_timeout_in, clkmon_timeout_in, avs_read, avs_write;
  logic [7:0] nv_legacy_opt_in, nv_portb_opt_in, avs_writedata, avs_readdata;
  logic [2:0] spi_drive_in, spi_oe_out;
  logic [15:0] avs_address;
  logic avs_waitrequest, legacy_mode_out, irq_level_sense_out, stop_clkmon_en_out;
  logic legacy_watchdog_en_out, legacy_watchdog_clear_out, security_out, full_wdog_regs_en_out;
  logic full_wdog_service_out, upper_map_en_out, overlay_low_ram_out, overlay_high_ram_out;
  logic portd_open_drain_out, reset_pin_o_out, reset_pin_oe_out;
  logic [7:0] portb_pullup_irq_en_out, full_wdog_ctrl_out, q;
  logic [6:0] portd_dir_out;
  int err_count = 0;
  int n_compared = 0;
  int svc_cnt = 0;
  int clr_cnt = 0;

  mocfg_top u_mocfg_top (.sys_clk_in, .reset_in, .por_in, .nv_legacy_opt_in, .nv_portb_opt_in,
    .wdog_timeout_in, .clkmon_timeout_in, .spi_drive_in, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .legacy_mode_out, .portb_pullup_irq_en_out,
    .irq_level_sense_out, .stop_clkmon_en_out, .legacy_watchdog_en_out,
    .legacy_watchdog_clear_out, .security_out, .full_wdog_regs_en_out, .full_wdog_service_out,
    .full_wdog_ctrl_out, .upper_map_en_out, .overlay_low_ram_out, .overlay_high_ram_out,
    .portd_dir_out, .spi_oe_out, .portd_open_drain_out, .reset_pin_o_out, .reset_pin_oe_out);

  // Free-running bus clock at 10 MHz.
  always #50 sys_clk_in = ~sys_clk_in;

  // Counting strobes lets a one-cycle pulse be seen whichever cycle it lands in.
  always @(posedge sys_clk_in) begin
    svc_cnt <= svc_cnt + int'(full_wdog_service_out);
    clr_cnt <= clr_cnt + int'(legacy_watchdog_clear_out);
  end

  task automatic complete_run();
    $display("Compared %0d values, %0d mismatches", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low; read data lands in q.
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk_in);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask

  // Expected {security, legacy watchdog, stop monitor, level sense}.
  function automatic logic [3:0] exp_flags(input logic lg, input logic [7:0] o, input logic sw);
    return {o[LMO_SEC_BIT], lg & o[LMO_WDOG_BIT], lg & o[LMO_STOP_BIT], lg ? o[LMO_IRQ_BIT] : sw};
  endfunction

  // Serial enables are gated by direction only in full map mode.
  function automatic logic [2:0] exp_oe(input logic lg, input logic [7:0] dir, input logic [2:0] drv);
    return lg ? drv : drv & {dir[PD_SCK], dir[PD_MOSI], dir[PD_MISO]};
  endfunction

  task automatic do_reset(input logic por, input logic [7:0] opt);
    @(posedge sys_clk_in);
    reset_in <= 1'h1;
    por_in <= por;
    nv_legacy_opt_in <= opt;
    nv_portb_opt_in <= 8'($urandom);
    repeat (4) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    if (por) chk(8'(reset_pin_oe_out), 8'h01, "power-on drive");
    @(posedge sys_clk_in);
    reset_in <= 1'h0;
    por_in <= 1'h0;
  endtask

  task automatic check_mode(input logic lg);
    logic [7:0] o, v, d;
    int s0, c0;
    o = nv_legacy_opt_in;
    @(negedge sys_clk_in);
    chk(8'(legacy_mode_out), 8'(lg), "mode");
    chk(portb_pullup_irq_en_out, nv_portb_opt_in, "port b options");
    chk({security_out, legacy_watchdog_en_out, stop_clkmon_en_out, irq_level_sense_out},
      8'(exp_flags(lg, o, 1'h1)), "option flags");
    chk({full_wdog_regs_en_out, upper_map_en_out}, {6'h00, ~lg, ~lg}, "map enables");
    bus(1'h0, ADDR_SW_OPTION, 8'h00);
    chk(q, lg ? BYTE_ZERO : SW_OPTION_RESET, "option read");
    bus(1'h0, ADDR_LEGACY_OPTION, 8'h00);
    chk(q & 8'h0E, lg ? o & 8'h0E : BYTE_ZERO, "legacy option read");
    bus(1'h1, ADDR_SW_OPTION, 8'h00);
    bus(1'h1, ADDR_SW_OPTION, 8'h02);
    bus(1'h0, ADDR_STATUS, 8'h00);
    chk(q & 8'h03, {6'h00, ~lg, lg}, "status");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      d = 8'($urandom);
      bus(1'h1, ADDR_SW_OPTION, v);
      spi_drive_in <= d[2:0];
      bus(1'h1, ADDR_PORTD_DIR, v);
      bus(1'h1, ADDR_SERIAL_CTRL, v);
      @(negedge sys_clk_in);
      chk({overlay_low_ram_out, overlay_high_ram_out},
        {6'h00, ~lg & v[SWO_LOW_BIT], ~lg & v[SWO_HIGH_BIT]}, "overlay");
      chk(8'(portd_dir_out), 8'(lg ? DIR_ZERO : v[6:0]), "port d dir");
      chk(8'(spi_oe_out), 8'(exp_oe(lg, v, d[2:0])), "serial enables");
      chk(8'(portd_open_drain_out), 8'(~lg & v[SPC_OPEN_DRAIN_BIT]), "open drain");
      chk(8'(irq_level_sense_out), 8'(lg & o[LMO_IRQ_BIT]), "sense write once");
    end
    bus(1'h1, ADDR_WDOG_CTRL, v);
    @(negedge sys_clk_in);
    chk(full_wdog_ctrl_out, lg ? BYTE_ZERO : v, "watchdog control");
    s0 = svc_cnt;
    c0 = clr_cnt;
    bus(1'h1, ADDR_WDOG_SERVICE, 8'h55);
    bus(1'h1, ADDR_LEGACY_CLEAR, 8'hAA);
    repeat (3) @(posedge sys_clk_in);
    chk(8'(svc_cnt - s0), {7'h00, ~lg}, "service pulses");
    chk(8'(clr_cnt - c0), {7'h00, lg}, "clear pulses");
    bus(1'h0, 16'h2000, 8'h00);
    chk(q, BYTE_ZERO, "unmapped read");
    // Each timeout source is held long enough for the registered drive to appear.
    for (int k = 1; k < 3; k++) begin
      {clkmon_timeout_in, wdog_timeout_in} <= 2'(k);
      repeat (2) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      chk({reset_pin_oe_out, reset_pin_o_out}, {6'h00, ~lg, 1'h0}, "reset pin");
      @(posedge sys_clk_in);
      {clkmon_timeout_in, wdog_timeout_in} <= 2'h0;
      repeat (3) @(posedge sys_clk_in);
    end
  endtask

  // Main sequence: power-on start, then legacy mode, then full mode without power-on.
  initial begin
    reset_in = 1'h1;
    por_in = 1'h1;
    nv_legacy_opt_in = 8'h00;
    nv_portb_opt_in = 8'h00;
    {wdog_timeout_in, clkmon_timeout_in, avs_read, avs_write} = 4'h0;
    spi_drive_in = 3'h0;
    avs_address = 16'h0000;
    avs_writedata = 8'h00;
    void'($urandom(73988));
    do_reset(1'h1, 8'($urandom) | 8'h01);
    check_mode(1'h0);
    do_reset(1'h0, 8'($urandom) | 8'h01);
    check_mode(1'h1);
    do_reset(1'h0, 8'($urandom) & 8'hFE);
    check_mode(1'h0);
    complete_run();
  end

  // The whole run needs well under a thousand cycles; this cuts a hang short.
  initial begin
    #500000;
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    complete_run();
  end
endmodule
